// ===== rtl/pss_pkg.sv
package pss_pkg;
    // geometry
    localparam int SIG_BITS = 64;
    localparam int CFG_BITS = 256;
    localparam int CFG_AW = 8;
    localparam int NUM_REGS = 12;
    // power-up clear time in ns and its cycle count at 200 MHz
    localparam int CLK_PERIOD_PS = 5000;
    localparam int POWER_UP_CLEAR_TIME_NS = 45000;
    localparam int POWER_UP_CLEAR_CYC = (POWER_UP_CLEAR_TIME_NS * 1000) / CLK_PERIOD_PS;
    // clock must be valid within this time; kept for reference by the bench
    localparam int CLOCK_VALID_AFTER_POWER_TIME_NS = 100;
    // cycles spent erasing the array before a program write lands
    localparam int ERASE_CYC = 256;
    // programmer mode codes
    typedef enum logic [2:0] {
        PSS_MODE_NORMAL = 3'b000,
        PSS_MODE_PROG = 3'b001,
        PSS_MODE_READ = 3'b010,
        PSS_MODE_SIG_WR = 3'b011,
        PSS_MODE_SIG_RD = 3'b100,
        PSS_MODE_SECURE = 3'b101,
        PSS_MODE_PRELOAD = 3'b110
    } pss_mode_t;
    typedef enum logic [1:0] {
        PSS_ST_RESET = 2'b00,
        PSS_ST_RUN = 2'b01,
        PSS_ST_ERASE = 2'b10,
        PSS_ST_WRITE = 2'b11
    } pss_state_t;
    localparam logic [7:0] CFG_ERASED = 8'hFF;
    localparam logic REG_CLEAR = 1'b0;
endpackage : pss_pkg

// ===== rtl/pss_cfg_mem.sv
`timescale 1ns/1ps
module pss_cfg_mem #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic clk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic rd_data_out
);
    // no reset on the array: nonvolatile contents survive power-up
    logic mem [DEPTH];
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule : pss_cfg_mem

// ===== rtl/pss_top.sv
`timescale 1ns/1ps
// Functional notes
// - a rewritable 64-bit store holds arbitrary user signature data
// - signature readback works whatever the security cell holds
// - once security is set, configuration readback is refused
// - security clears on rst_in or when a programming cycle enters erase
// - every programming cycle erases the array by itself first
// - each registered output may be forced high or low synchronously
// - after power-up every register is cleared low within 45 us
// - undriven pins read as logic 1 through the pull-up
module pss_top #(
    parameter int NUM_REGS = pss_pkg::NUM_REGS,
    parameter int CLEAR_CYC = pss_pkg::POWER_UP_CLEAR_CYC,
    parameter int ERASE_CYC = pss_pkg::ERASE_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [2:0] mode_in,
    input wire logic strobe_in,
    input wire logic [pss_pkg::CFG_AW-1:0] addr_in,
    input wire logic data_in,
    input wire logic data_oe_in,
    input wire logic [NUM_REGS-1:0] pin_in,
    input wire logic [NUM_REGS-1:0] pin_driven_in,
    input wire logic [NUM_REGS-1:0] d_in,
    output logic data_out,
    output logic data_valid_out,
    output logic refused_out,
    output logic busy_out,
    output logic secure_out,
    output logic ready_out,
    output logic [NUM_REGS-1:0] pin_level_out,
    output logic [NUM_REGS-1:0] q_out
);
    // ****************************************
    // modes and pin levels
    // ****************************************
    pss_pkg::pss_state_t state_r;
    logic [31:0] cnt_r;
    logic [pss_pkg::SIG_BITS-1:0] sig_r;
    logic secure_r;
    logic [pss_pkg::CFG_AW-1:0] eaddr_r;
    logic pend_data_r;
    logic [pss_pkg::CFG_AW-1:0] pend_addr_r;
    logic rd_pend_r;
    logic rd_sig_r;
    localparam int SIG_AW = $clog2(pss_pkg::SIG_BITS);
    logic [SIG_AW-1:0] sig_idx_r;
    logic mem_q;
    logic mem_we;
    logic [pss_pkg::CFG_AW-1:0] mem_wa;
    logic mem_wd;
    logic data_lvl;
    logic run;
    logic [NUM_REGS-1:0] pin_lvl;

    assign run = (state_r == pss_pkg::PSS_ST_RUN);
    assign data_lvl = data_oe_in ? data_in : 1'b1;
    assign pin_lvl = pin_in | ~pin_driven_in;
    assign pin_level_out = pin_lvl;
    assign busy_out = (state_r == pss_pkg::PSS_ST_ERASE) || (state_r == pss_pkg::PSS_ST_WRITE);
    assign ready_out = run;
    assign secure_out = secure_r;

    function automatic logic mode_is(input logic [2:0] m, input pss_pkg::pss_mode_t c);
        mode_is = (m == c);
    endfunction : mode_is

    // ****************************************
    // power-up clear and programming sequencer
    // ****************************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= pss_pkg::PSS_ST_RESET;
            cnt_r <= '0;
            eaddr_r <= '0;
            pend_data_r <= 1'b0;
            pend_addr_r <= '0;
        end else begin
            unique case (state_r)
                pss_pkg::PSS_ST_RESET: begin
                    // clear time counted from reset release
                    if (cnt_r >= 32'(CLEAR_CYC - 1)) begin
                        state_r <= pss_pkg::PSS_ST_RUN;
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + 32'h0000_0001;
                    end
                end
                pss_pkg::PSS_ST_RUN: begin
                    if (strobe_in && mode_is(mode_in, pss_pkg::PSS_MODE_PROG)) begin
                        // erase is implicit, programmer never asks for it
                        state_r <= pss_pkg::PSS_ST_ERASE;
                        eaddr_r <= '0;
                        pend_data_r <= data_lvl;
                        pend_addr_r <= addr_in;
                    end
                end
                pss_pkg::PSS_ST_ERASE: begin
                    eaddr_r <= eaddr_r + 8'h01;
                    if (eaddr_r == 8'(ERASE_CYC - 1)) begin
                        state_r <= pss_pkg::PSS_ST_WRITE;
                    end
                end
                pss_pkg::PSS_ST_WRITE: begin
                    state_r <= pss_pkg::PSS_ST_RUN;
                end
            endcase
        end
    end

    assign mem_we = (state_r == pss_pkg::PSS_ST_ERASE) || (state_r == pss_pkg::PSS_ST_WRITE);
    assign mem_wa = (state_r == pss_pkg::PSS_ST_ERASE) ? eaddr_r : pend_addr_r;
    assign mem_wd = (state_r == pss_pkg::PSS_ST_ERASE) ? pss_pkg::CFG_ERASED[0] : pend_data_r;

    pss_cfg_mem #(
        .DEPTH(pss_pkg::CFG_BITS),
        .AW(pss_pkg::CFG_AW)
    ) u_mem (
        .clk_in(clk_in),
        .wr_en_in(mem_we),
        .wr_addr_in(mem_wa),
        .wr_data_in(mem_wd),
        .rd_addr_in(addr_in),
        .rd_data_out(mem_q)
    );

    // ****************************************
    // security cell and signature store
    // ****************************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            secure_r <= 1'b0;
        end else if (state_r == pss_pkg::PSS_ST_ERASE) begin
            secure_r <= 1'b0;
        end else if (run && strobe_in && mode_is(mode_in, pss_pkg::PSS_MODE_SECURE)) begin
            secure_r <= 1'b1;
        end
    end

    // store not cleared by reset: its contents are nonvolatile
    always_ff @(posedge clk_in) begin
        if (run && strobe_in && mode_is(mode_in, pss_pkg::PSS_MODE_SIG_WR)) begin
            sig_r[addr_in[SIG_AW-1:0]] <= data_lvl;
        end
    end

    // ****************************************
    // readback
    // ****************************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_pend_r <= 1'b0;
            rd_sig_r <= 1'b0;
            sig_idx_r <= '0;
            refused_out <= 1'b0;
        end else begin
            rd_pend_r <= run && strobe_in && mode_is(mode_in, pss_pkg::PSS_MODE_READ) && !secure_r;
            rd_sig_r <= run && strobe_in && mode_is(mode_in, pss_pkg::PSS_MODE_SIG_RD);
            sig_idx_r <= addr_in[SIG_AW-1:0];
            refused_out <= run && strobe_in && mode_is(mode_in, pss_pkg::PSS_MODE_READ)
                && secure_r;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_out <= 1'b0;
            data_valid_out <= 1'b0;
        end else begin
            data_valid_out <= rd_pend_r || rd_sig_r;
            if (rd_sig_r) begin
                data_out <= sig_r[sig_idx_r];
            end else if (rd_pend_r) begin
                data_out <= mem_q;
            end else begin
                data_out <= 1'b0;
            end
        end
    end

    // ****************************************
    // registered outputs with preload
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    q_out[gi] <= pss_pkg::REG_CLEAR;
                end else if (state_r == pss_pkg::PSS_ST_RESET) begin
                    q_out[gi] <= pss_pkg::REG_CLEAR;
                end else if (run && mode_is(mode_in, pss_pkg::PSS_MODE_PRELOAD)) begin
                    // only the preload mode reaches this path
                    if (strobe_in) begin
                        q_out[gi] <= pin_lvl[gi];
                    end
                end else if (run && mode_is(mode_in, pss_pkg::PSS_MODE_NORMAL)) begin
                    q_out[gi] <= d_in[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // checks
    // ****************************************
    AST_SEC_REFUSE: assert property (@(posedge clk_in) disable iff (rst_in)
        (run && strobe_in && mode_in == pss_pkg::PSS_MODE_READ && secure_r)
        |=> refused_out && !rd_pend_r)
        else $error("config read not refused while secure");
    AST_SIG_READ: assert property (@(posedge clk_in) disable iff (rst_in)
        (run && strobe_in && mode_in == pss_pkg::PSS_MODE_SIG_RD) |=> ##1 data_valid_out)
        else $error("signature read gave no data");
    AST_SEC_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
        ($fell(secure_r)) |-> $past(state_r) == pss_pkg::PSS_ST_ERASE)
        else $error("security cleared outside programming");
    AST_AUTO_ERASE: assert property (@(posedge clk_in) disable iff (rst_in)
        // security drops one cycle into the erase, not at the strobe
        (run && strobe_in && mode_in == pss_pkg::PSS_MODE_PROG)
        |=> busy_out ##1 (busy_out && !secure_r))
        else $error("programming did not start erase");
    AST_PRELOAD: assert property (@(posedge clk_in) disable iff (rst_in)
        (run && strobe_in && mode_in == pss_pkg::PSS_MODE_PRELOAD) |=> q_out == $past(pin_lvl))
        else $error("preload value not loaded");
    AST_NO_PRELOAD_NORMAL: assert property (@(posedge clk_in) disable iff (rst_in)
        (run && mode_in == pss_pkg::PSS_MODE_NORMAL) |=> q_out == $past(d_in))
        else $error("normal mode did not follow data");
    AST_CLEAR_LOW: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_r == pss_pkg::PSS_ST_RESET) |-> q_out == '0)
        else $error("register not clear during power-up");
    AST_PULLUP: assert property (@(posedge clk_in) disable iff (rst_in)
        (pin_driven_in == '0) |-> pin_level_out == '1)
        else $error("undriven pin not read high");
endmodule : pss_top

// ===== verif/pss_prog_model.sv
`timescale 1ns/1ps
// ****************************
// programmer and tester model
// ****************************
module pss_prog_model (
    input wire logic clk_in,
    input wire logic ready_in,
    output logic [2:0] mode_out,
    output logic strobe_out,
    output logic [7:0] addr_out,
    output logic data_out,
    output logic data_oe_out
);
    // pins start idle; the clock runs from time zero
    initial begin
        mode_out = 3'h0;
        strobe_out = 1'b0;
        addr_out = 8'h00;
        data_out = 1'b1;
        data_oe_out = 1'b0;
    end
    // no request until setup after reset is met
    task automatic req(input logic [2:0] m, input logic [7:0] a, input logic d, input logic oe);
        int n;
        n = 0;
        #1;
        while (ready_in !== 1'b1 && n < 400) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        @(posedge clk_in);
        mode_out <= m;
        addr_out <= a;
        data_out <= d;
        data_oe_out <= oe;
        strobe_out <= 1'b1;
        @(posedge clk_in);
        strobe_out <= 1'b0;
        // address held, pin released to the pull-up level
        data_oe_out <= 1'b0;
        data_out <= 1'b1;
    endtask : req
    task automatic set_mode(input logic [2:0] m);
        @(posedge clk_in);
        mode_out <= m;
    endtask : set_mode
endmodule : pss_prog_model

// ===== verif/test_pss_top.sv
`timescale 1ns/1ps
// *****************************
// bench for the housekeeping block
// *****************************
module test_pss_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [11:0] pin_in = 12'h000;
    logic [11:0] pin_driven_in = 12'h000;
    logic [11:0] d_in = 12'h000;
    logic [2:0] mode_in;
    logic [7:0] addr_in;
    logic strobe_in, data_in, data_oe_in, data_out, data_valid_out, refused_out;
    logic busy_out, secure_out, ready_out;
    logic [11:0] pin_level_out, q_out;
    int n_fail = 0;
    int checked = 0;
    always #2.5 clk_in = ~clk_in;
    pss_top #(.NUM_REGS(12), .CLEAR_CYC(4), .ERASE_CYC(256)) DUT (.clk_in, .rst_in,
        .mode_in, .strobe_in, .addr_in, .data_in, .data_oe_in, .pin_in, .pin_driven_in,
        .d_in, .data_out, .data_valid_out, .refused_out, .busy_out, .secure_out,
        .ready_out, .pin_level_out, .q_out);
    pss_prog_model P (.clk_in(clk_in), .ready_in(ready_out), .mode_out(mode_in),
        .strobe_out(strobe_in), .addr_out(addr_in), .data_out(data_in),
        .data_oe_out(data_oe_in));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic watch(output int kv, output int kr, output logic b);
        kv = -1;
        kr = -1;
        b = 1'bx;
        for (int k = 0; k < 4; k++) begin
            #1;
            if (data_valid_out === 1'b1 && kv < 0) begin
                kv = k;
                b = data_out;
            end
            if (refused_out === 1'b1 && kr < 0) kr = k;
            @(posedge clk_in);
        end
    endtask : watch
    task automatic rd(input logic [2:0] m, input logic [7:0] a, input logic exp, input logic ok);
        int kv, kr;
        logic b;
        P.req(m, a, 1'b1, 1'b0);
        watch(kv, kr, b);
        chk(12'(kv), ok ? 12'h001 : 12'hFFF);
        chk(12'(kr), ok ? 12'hFFF : 12'h000);
        if (ok) chk(12'(b), 12'(exp));
    endtask : rd
    task automatic wait_rdy(output int n);
        n = 0;
        #1;
        while (ready_out !== 1'b1 && n < 400) begin
            @(posedge clk_in);
            #1;
            n++;
        end
    endtask : wait_rdy
    task automatic prog(input logic [7:0] a, input logic d);
        int n;
        P.req(3'h1, a, d, 1'b1);
        #1;
        chk(12'(busy_out), 12'h001);
        wait_rdy(n);
        chk(12'(n), 12'(pss_pkg::ERASE_CYC + 1));
    endtask : prog
    task automatic t_reset;
        int n;
        @(posedge clk_in);
        chk(12'($time < pss_pkg::CLOCK_VALID_AFTER_POWER_TIME_NS), 12'h001);
        repeat (4) @(posedge clk_in);
        #1;
        chk(q_out, 12'h000);
        chk(12'(ready_out), 12'h000);
        @(posedge clk_in);
        rst_in <= 1'b0;
        wait_rdy(n);
        chk(12'(n >= 1 && n <= 5), 12'h001);
        chk(q_out, 12'h000);
    endtask : t_reset
    task automatic t_sig;
        P.req(3'h3, 8'h00, 1'b1, 1'b1);
        P.req(3'h3, 8'h3F, 1'b0, 1'b1);
        P.req(3'h3, 8'h05, 1'b0, 1'b0);
        rd(3'h4, 8'h00, 1'b1, 1'b1);
        rd(3'h4, 8'h3F, 1'b0, 1'b1);
        rd(3'h4, 8'h05, 1'b1, 1'b1);
    endtask : t_sig
    task automatic t_secure;
        prog(8'h07, 1'b0);
        rd(3'h2, 8'h07, 1'b0, 1'b1);
        rd(3'h2, 8'h08, 1'b1, 1'b1);
        P.req(3'h5, 8'h00, 1'b1, 1'b1);
        #1;
        chk(12'(secure_out), 12'h001);
        rd(3'h2, 8'h07, 1'b0, 1'b0);
        rd(3'h4, 8'h00, 1'b1, 1'b1);
        prog(8'h09, 1'b0);
        chk(12'(secure_out), 12'h000);
        rd(3'h2, 8'h07, 1'b1, 1'b1);
        rd(3'h2, 8'h09, 1'b0, 1'b1);
    endtask : t_secure
    task automatic t_preload;
        @(posedge clk_in);
        pin_in <= 12'hA5C;
        pin_driven_in <= 12'hF0F;
        P.req(3'h6, 8'h00, 1'b1, 1'b0);
        #1;
        chk(pin_level_out, 12'hAFC);
        chk(q_out, 12'hAFC);
        P.set_mode(3'h0);
        d_in <= 12'h3C5;
        repeat (2) @(posedge clk_in);
        #1;
        chk(q_out, 12'h3C5);
        P.req(3'h0, 8'h00, 1'b1, 1'b0);
        #1;
        chk(q_out, 12'h3C5);
    endtask : t_preload
    task give_verdict;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    // whole run is near 600 cycles; 10000 cycles is a hang
    initial begin
        #50000;
        n_fail++;
        give_verdict;
    end
    initial begin
        t_reset;
        t_sig;
        t_secure;
        t_preload;
        give_verdict;
    end
endmodule : test_pss_top
